// ==== ilk_diag_top.v ====
// Guard interlock status logic: indicators, red flash codes, safety
// output switch-off, diagnostic output, fault clearing, APB registers.
// Assumes all sensing and fault inputs are asynchronous pins.
//
// How it works
// [R1] Output 1 fault: red one-pulse bursts, outputs off after thirty minutes.
// [R2] Output 2 fault: red two-pulse bursts, outputs off after thirty minutes.
// [R3] Cross-wire or both outputs: three pulses, off later, only reset recovers.
// [R4] Wrong or defective actuator: outputs off at once, five-pulse bursts.
// [R5] Holding force detector fault: outputs off at once, six-pulse bursts.
// [R6] Magnet overtemperature: outputs off at once, ten-pulse bursts.
// [R7] Internal failure: outputs off at once and latched, red lit continuously.
// [R8] Latched failure clears on guard open then close; outputs return when locked.
// [R9] Warning keeps outputs on, red flashes, diag low, escalates after delay.
// [R10] Closed, actuator present, no lock command: yellow flashes, diag high.
// [R11] Lock command and locked guard: yellow steady, outputs and diag high.
// [R12] Lock command but force too low: yellow flashes, outputs and diag low.
// [R13] Actuator near sensing limit: yellow flashes as early warning.
// [R14] Red codes are pulse bursts then a longer dark pause, repeating.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ilk_defines.vh"
module ilk_diag_top #(
  parameter [39:0] DELAY_CYCLES = `ILK_DELAY_CYC,
  parameter [31:0] FLASH_CYCLES = `ILK_FLASH_CYC
) (
  input wire mclk,
  input wire sys_rst,
  input wire pinGuardClosed,
  input wire pinActPresent,
  input wire pinActMarginal,
  input wire pinLockEngaged,
  input wire pinForceOk,
  input wire pinLockCmd,
  input wire pinErrOut1,
  input wire pinErrOut2,
  input wire pinErrCross,
  input wire pinErrActuator,
  input wire pinErrForce,
  input wire pinErrTemp,
  input wire pinErrInternal,
  output reg first_safety_output,
  output reg second_safety_output,
  output reg diagOut,
  output reg ledGreen,
  output wire ledYellow,
  output wire ledRed,
  output wire irq,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr
);
  localparam NIN = 13;

  // Two-stage synchroniser for all sensing and fault pins
  reg [NIN-1:0] syncA_r;
  reg [NIN-1:0] syncB_r;
  wire [NIN-1:0] pinVec;
  assign pinVec = {pinGuardClosed, pinActPresent, pinActMarginal, pinLockEngaged,
    pinForceOk, pinLockCmd, pinErrOut1, pinErrOut2, pinErrCross, pinErrActuator,
    pinErrForce, pinErrTemp, pinErrInternal};

  always @(posedge mclk) begin
    if (sys_rst) begin
      syncA_r <= {NIN{1'b0}};
      syncB_r <= {NIN{1'b0}};
    end else begin
      syncA_r <= pinVec;
      syncB_r <= syncA_r;
    end
  end

  wire guardClosed = syncB_r[12];
  wire actPresent = syncB_r[11];
  wire actMarginal = syncB_r[10];
  wire lockEngaged = syncB_r[9];
  wire forceOk = syncB_r[8];
  wire lockCmd = syncB_r[7];
  wire errOut1 = syncB_r[6];
  wire errOut2 = syncB_r[5];
  wire errCross = syncB_r[4];
  wire errActuator = syncB_r[3];
  wire errForce = syncB_r[2];
  wire errTemp = syncB_r[1];
  wire errInternal = syncB_r[0];

  reg failLatched_r;
  reg [3:0] failCode_r;
  reg failSticky_r;
  reg guardOpened_r;
  reg warnPrev_r;
  reg ctrlIndEn_r;
  reg [`ILK_IRQ_W-1:0] irqStat_r;
  reg [`ILK_IRQ_W-1:0] irqEn_r;
  reg yelBlink_r;

  // Delayed switch-off faults
  wire bothOut = errOut1 && errOut2;
  wire warnCause = errOut1 || errOut2 || errCross;
  wire warnActive = warnCause && !failLatched_r; // [R9]
  reg [3:0] warnCode;
  always @* begin
    if (errCross || bothOut) begin
      warnCode = `ILK_CODE_CROSS; // [R3]
    end else if (errOut2) begin
      warnCode = `ILK_CODE_OUT2; // [R2]
    end else if (errOut1) begin
      warnCode = `ILK_CODE_OUT1; // [R1]
    end else begin
      warnCode = `ILK_CODE_NONE;
    end
  end

  wire warnExpired;
  ilk_delay_timer #(
    .CYCLES(DELAY_CYCLES)
  ) u_delay (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(warnActive),
    .expired(warnExpired)
  );

  // Immediate switch-off faults
  wire immCause = errActuator || errForce || errTemp;
  reg [3:0] immCode;
  always @* begin
    if (errInternal) begin
      immCode = `ILK_CODE_INT; // [R7]
    end else if (errActuator) begin
      immCode = `ILK_CODE_ACT; // [R4]
    end else if (errForce) begin
      immCode = `ILK_CODE_FORCE; // [R5]
    end else if (errTemp) begin
      immCode = `ILK_CODE_TEMP; // [R6]
    end else begin
      immCode = `ILK_CODE_NONE;
    end
  end

  wire failCause = immCause || errInternal || (warnActive && warnExpired);
  // Warning causes hold a latched failure too, although the timer is idle then
  wire causeGone = !failCause && !warnCause;
  wire failClear = failLatched_r && causeGone && !failSticky_r && guardOpened_r &&
    guardClosed; // [R8]

  always @(posedge mclk) begin
    if (sys_rst) begin
      failLatched_r <= 1'b0;
      failCode_r <= `ILK_CODE_NONE;
      failSticky_r <= 1'b0;
      guardOpened_r <= 1'b0;
    end else if (!failLatched_r) begin
      guardOpened_r <= 1'b0;
      if (failCause) begin
        failLatched_r <= 1'b1;
        if (immCause || errInternal) begin
          failCode_r <= immCode; // [R4] [R5] [R6] [R7]
        end else begin
          failCode_r <= warnCode; // [R9]
          failSticky_r <= (warnCode == `ILK_CODE_CROSS); // [R3]
        end
      end
    end else if (failClear) begin
      failLatched_r <= 1'b0; // [R8]
      failCode_r <= `ILK_CODE_NONE;
      guardOpened_r <= 1'b0;
    end else if (causeGone && !guardClosed) begin
      guardOpened_r <= 1'b1; // [R8]
    end
  end

  // Safety outputs and diagnostic output
  wire lockedOk = lockEngaged && forceOk;
  wire safeOk = guardClosed && actPresent && lockCmd && lockedOk && !failLatched_r &&
    !immCause && !errInternal; // [R4] [R5] [R6] [R7] [R8] [R11] [R12]
  wire diagOk = guardClosed && actPresent && !warnActive && !failLatched_r &&
    !errInternal && (!lockCmd || lockedOk); // [R9] [R10] [R11] [R12]

  always @(posedge mclk) begin
    if (sys_rst) begin
      first_safety_output <= 1'b0;
      second_safety_output <= 1'b0;
      diagOut <= 1'b0;
      ledGreen <= 1'b0;
    end else begin
      first_safety_output <= safeOk;
      second_safety_output <= safeOk;
      diagOut <= diagOk;
      ledGreen <= ctrlIndEn_r;
    end
  end

  // Indicators
  wire redActive = ctrlIndEn_r && (failLatched_r || warnActive || errInternal);
  wire redSolid = errInternal || (failLatched_r && failCode_r == `ILK_CODE_INT); // [R7]
  wire [3:0] redCode = failLatched_r ? failCode_r : warnCode; // [R9]
  wire flashTick;

  ilk_flash_gen #(
    .TICK_CYCLES(FLASH_CYCLES),
    .PAUSE_TICKS(`ILK_PAUSE_TICKS)
  ) u_flash (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .active(redActive),
    .solid(redSolid),
    .pulses(redCode),
    .led(ledRed),
    .tick(flashTick)
  );

  wire yelSolid = safeOk && !actMarginal; // [R11]
  wire yelFlash = guardClosed && actPresent && !failLatched_r && !errInternal &&
    (!safeOk || actMarginal); // [R10] [R12] [R13]

  always @(posedge mclk) begin
    if (sys_rst) begin
      yelBlink_r <= 1'b0;
    end else if (flashTick) begin
      yelBlink_r <= !yelBlink_r;
    end
  end

  assign ledYellow = ctrlIndEn_r && (yelSolid || (yelFlash && yelBlink_r));

  // Interrupt events
  wire [`ILK_IRQ_W-1:0] irqEvent;
  assign irqEvent[`ILK_IRQ_FAIL] = !failLatched_r && failCause;
  assign irqEvent[`ILK_IRQ_WARN] = warnActive && !warnPrev_r;
  assign irqEvent[`ILK_IRQ_CLEARED] = failClear;
  assign irqEvent[`ILK_IRQ_OFF] = first_safety_output && !safeOk;

  // APB slave, zero wait states
  wire apbSetup = psel && !penable;
  wire apbWrite = psel && penable && pwrite;
  assign pready = 1'b1;

  reg [31:0] rdData;
  reg rdErr;
  always @* begin
    rdData = 32'h0;
    rdErr = 1'b0;
    if (paddr == `ILK_ADDR_CTRL) begin
      rdData[`ILK_CTRL_IND_EN] = ctrlIndEn_r;
    end else if (paddr == `ILK_ADDR_STATUS) begin
      rdData[`ILK_ST_SAFE] = first_safety_output;
      rdData[`ILK_ST_DIAG] = diagOut;
      rdData[`ILK_ST_WARN] = warnActive;
      rdData[`ILK_ST_FAIL] = failLatched_r;
      rdData[`ILK_ST_GUARD] = guardClosed;
      rdData[`ILK_ST_LOCKED] = lockedOk;
      rdData[`ILK_ST_STICKY] = failSticky_r;
      rdData[`ILK_ST_WCODE+3:`ILK_ST_WCODE] = warnCode;
      rdData[`ILK_ST_FCODE+3:`ILK_ST_FCODE] = failCode_r;
    end else if (paddr == `ILK_ADDR_IRQ_STAT) begin
      rdData[`ILK_IRQ_W-1:0] = irqStat_r;
    end else if (paddr == `ILK_ADDR_IRQ_CLR) begin
      rdData = 32'h0;
    end else if (paddr == `ILK_ADDR_IRQ_EN) begin
      rdData[`ILK_IRQ_W-1:0] = irqEn_r;
    end else begin
      rdErr = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      prdata <= pwrite ? 32'h0 : rdData;
      pslverr <= rdErr;
    end
  end

  wire [`ILK_IRQ_W-1:0] irqClr = (apbWrite && paddr == `ILK_ADDR_IRQ_CLR) ?
    pwdata[`ILK_IRQ_W-1:0] : {`ILK_IRQ_W{1'b0}};

  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrlIndEn_r <= `ILK_CTRL_RESET;
      irqEn_r <= `ILK_IRQ_EN_RESET;
      irqStat_r <= {`ILK_IRQ_W{1'b0}};
      warnPrev_r <= 1'b0;
    end else begin
      warnPrev_r <= warnActive;
      // Set wins over a clear in the same cycle
      irqStat_r <= (irqStat_r & ~irqClr) | irqEvent;
      if (apbWrite && paddr == `ILK_ADDR_CTRL) begin
        ctrlIndEn_r <= pwdata[`ILK_CTRL_IND_EN];
      end
      if (apbWrite && paddr == `ILK_ADDR_IRQ_EN) begin
        irqEn_r <= pwdata[`ILK_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irqStat_r & irqEn_r);
endmodule // ilk_diag_top
`default_nettype wire

// ==== ilk_defines.vh ====
// Constants of the guard interlock status logic: register offsets,
// fields, reset values, flash codes and timing figures.
// Assumes a 125 MHz system clock and an APB register port.
`ifndef ILK_DEFINES_VH
`define ILK_DEFINES_VH

// Register byte offsets
`define ILK_ADDR_CTRL 8'h00
`define ILK_ADDR_STATUS 8'h04
`define ILK_ADDR_IRQ_STAT 8'h08
`define ILK_ADDR_IRQ_CLR 8'h0C
`define ILK_ADDR_IRQ_EN 8'h10

// Control fields and reset values
`define ILK_CTRL_IND_EN 0
`define ILK_CTRL_RESET 1'h1
`define ILK_IRQ_EN_RESET 4'h0

// Status fields
`define ILK_ST_SAFE 0
`define ILK_ST_DIAG 1
`define ILK_ST_WARN 2
`define ILK_ST_FAIL 3
`define ILK_ST_GUARD 4
`define ILK_ST_LOCKED 5
`define ILK_ST_STICKY 6
`define ILK_ST_WCODE 8
`define ILK_ST_FCODE 12

// Interrupt event bits
`define ILK_IRQ_FAIL 0
`define ILK_IRQ_WARN 1
`define ILK_IRQ_CLEARED 2
`define ILK_IRQ_OFF 3
`define ILK_IRQ_W 4

// Red flash codes (pulses per burst); INT means continuously lit
`define ILK_CODE_NONE 4'h0
`define ILK_CODE_OUT1 4'h1
`define ILK_CODE_OUT2 4'h2
`define ILK_CODE_CROSS 4'h3
`define ILK_CODE_ACT 4'h5
`define ILK_CODE_FORCE 4'h6
`define ILK_CODE_TEMP 4'hA
`define ILK_CODE_INT 4'hF

// Timing
`define ILK_CLK_HZ 125000000
`define ILK_DELAY_MIN 30
`define ILK_DELAY_CYC (`ILK_DELAY_MIN * 40'd60 * `ILK_CLK_HZ)
`define ILK_FLASH_MS 250
`define ILK_FLASH_CYC (`ILK_FLASH_MS * (`ILK_CLK_HZ / 1000))
`define ILK_PAUSE_TICKS 4'h6

`endif

// ==== ilk_delay_timer.v ====
// Delayed switch-off timer: counts while run is high, flags expiry.
// Assumes run is a synchronous level on mclk.
`timescale 1ns/1ps
`default_nettype none
module ilk_delay_timer #(
  parameter [39:0] CYCLES = 40'd1000
) (
  input wire mclk,
  input wire sys_rst,
  input wire run,
  output reg expired
);
  reg [39:0] cnt_r;

  always @(posedge mclk) begin
    if (sys_rst || !run) begin
      cnt_r <= 40'h0;
      expired <= 1'b0;
    end else if (cnt_r == CYCLES - 40'h1) begin
      expired <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 40'h1;
    end
  end
endmodule // ilk_delay_timer
`default_nettype wire

// ==== ilk_flash_gen.v ====
// Red flash burst generator: bursts of N pulses, then a dark pause.
// Also exports the base tick for other blinking indicators.
// Assumes code inputs are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module ilk_flash_gen #(
  parameter [31:0] TICK_CYCLES = 32'd1000,
  parameter [3:0] PAUSE_TICKS = 4'h6
) (
  input wire mclk,
  input wire sys_rst,
  input wire active,
  input wire solid,
  input wire [3:0] pulses,
  output reg led,
  output wire tick
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_ON = 4'b0010;
  localparam [3:0] S_OFF = 4'b0100;
  localparam [3:0] S_PAUSE = 4'b1000;

  reg [31:0] divCnt_r;
  reg [3:0] state_r;
  reg [3:0] pulseCnt_r;
  reg [3:0] pauseCnt_r;

  assign tick = (divCnt_r == TICK_CYCLES - 32'h1);

  always @(posedge mclk) begin
    if (sys_rst || tick) begin
      divCnt_r <= 32'h0;
    end else begin
      divCnt_r <= divCnt_r + 32'h1;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst || !active || solid) begin
      state_r <= S_IDLE;
      pulseCnt_r <= 4'h0;
      pauseCnt_r <= 4'h0;
      led <= !sys_rst && active && solid;
    end else if (tick) begin
      case (state_r)
        S_IDLE: begin
          state_r <= S_ON;
          pulseCnt_r <= 4'h1;
          led <= 1'b1;
        end
        S_ON: begin
          state_r <= S_OFF;
          led <= 1'b0;
        end
        S_OFF: begin
          if (pulseCnt_r >= pulses) begin // [R14]
            state_r <= S_PAUSE;
            pauseCnt_r <= 4'h0;
          end else begin
            state_r <= S_ON;
            pulseCnt_r <= pulseCnt_r + 4'h1;
            led <= 1'b1;
          end
        end
        S_PAUSE: begin
          if (pauseCnt_r >= PAUSE_TICKS - 4'h1) begin // [R14]
            state_r <= S_ON;
            pulseCnt_r <= 4'h1;
            led <= 1'b1;
          end else begin
            pauseCnt_r <= pauseCnt_r + 4'h1;
          end
        end
        default: begin
          state_r <= S_IDLE;
          led <= 1'b0;
        end
      endcase
    end
  end
endmodule // ilk_flash_gen
`default_nettype wire

// ==== ilk_diag_monitor.sv ====
// Port checker for the interlock status logic, bound to its top.
// Assumes pins change just after mclk edges and pass a 2-FF sync.
`timescale 1ns/1ps
`default_nettype none
module ilk_diag_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pinGuardClosed,
  input wire logic pinForceOk,
  input wire logic pinLockCmd,
  input wire logic pinErrOut1,
  input wire logic pinErrActuator,
  input wire logic pinErrForce,
  input wire logic pinErrTemp,
  input wire logic pinErrInternal,
  input wire logic first_safety_output,
  input wire logic second_safety_output,
  input wire logic diagOut,
  input wire logic ledGreen,
  input wire logic ledRed
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  outputs_paired_a: assert property (first_safety_output == second_safety_output)
    else $error("safety outputs differ");
  actuator_off_a: assert property (pinErrActuator [*3] |=> !first_safety_output)
    else $error("outputs on with actuator fault");
  force_off_a: assert property (pinErrForce [*3] |=> !first_safety_output)
    else $error("outputs on with force fault");
  temp_off_a: assert property (pinErrTemp [*3] |=> !first_safety_output)
    else $error("outputs on with hot magnet");
  internal_red_a: assert property (pinErrInternal [*6] ##0 ledGreen |-> ledRed)
    else $error("red not solid on internal fault");
  on_conditions_a: assert property (first_safety_output |-> $past(pinGuardClosed, 3)
    && $past(pinLockCmd, 3) && $past(pinForceOk, 3))
    else $error("outputs on without lock conditions");
  warn_diag_low_a: assert property ($past(pinErrOut1, 3) |-> !diagOut)
    else $error("diag high during warning");
  open_diag_low_a: assert property (!$past(pinGuardClosed, 3) |-> !diagOut)
    else $error("diag high with guard open");
endmodule // ilk_diag_monitor
bind ilk_diag_top ilk_diag_monitor u_ilk_diag_monitor (.*);
`default_nettype wire

// ==== ilk_ctrl_model.sv ====
// Safety controller model: lock command after a lag, output watch.
// Assumes lag is held steady while a request is pending.
`timescale 1ns/1ps
`default_nettype none
module ilk_ctrl_model (
  input wire logic mclk,
  input wire logic lockReq,
  input wire logic [3:0] lag,
  input wire logic out1,
  input wire logic out2,
  output var logic lockCmd,
  output var logic pairBad
);
  logic [3:0] waitCnt;
  initial begin
    lockCmd = 1'h0;
    pairBad = 1'h0;
    waitCnt = 4'h0;
  end
  always @(posedge mclk) begin
    if (lockReq == lockCmd) waitCnt <= 4'h0;
    else if (waitCnt >= lag) lockCmd <= lockReq;
    else waitCnt <= waitCnt + 4'h1;
    if (out1 !== out2) pairBad <= 1'h1;
  end
endmodule // ilk_ctrl_model
`default_nettype wire

// ==== ilk_diag_top_bench.sv ====
// Self-checking bench for the interlock status logic.
// Assumes the bound checker and the controller model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "ilk_defines.vh"
module ilk_diag_top_bench;
  logic mclk, sys_rst, pinGuardClosed, pinActPresent, pinActMarginal, pinLockEngaged;
  logic pinForceOk, pinLockCmd, lockReq, pairBad, psel, penable, pwrite, rdErr;
  logic first_safety_output, second_safety_output, diagOut, ledGreen, ledYellow;
  logic ledRed, irq, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] err;
  logic [3:0] lag;
  int mismatches, checks_done, cyc;
  wire pinErrOut1 = err[0];
  wire pinErrOut2 = err[1];
  wire pinErrCross = err[2];
  wire pinErrActuator = err[3];
  wire pinErrForce = err[4];
  wire pinErrTemp = err[5];
  wire pinErrInternal = err[6];
  ilk_diag_top #(.DELAY_CYCLES(40'd600), .FLASH_CYCLES(32'd4)) u_ilk_diag_top (.*);
  ilk_ctrl_model u_ilk_ctrl_model (.mclk(mclk), .lockReq(lockReq), .lag(lag),
    .out1(first_safety_output), .out2(second_safety_output), .lockCmd(pinLockCmd),
    .pairBad(pairBad));
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chkWord(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chkBit(input logic g, input logic e);
    chkWord({31'h0, g}, {31'h0, e});
  endtask
  task wc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task setp(input logic g, input logic a, input logic lk, input logic f);
    pinGuardClosed <= g;
    pinActPresent <= a;
    pinLockEngaged <= lk;
    pinForceOk <= f;
    wc(14);
  endtask
  task blink(output logic b);
    logic s0, s1;
    s0 = 1'h0;
    s1 = 1'h0;
    repeat (20) begin
      @(posedge mclk);
      if (ledYellow === 1'h1) s1 = 1'h1;
      else if (ledYellow === 1'h0) s0 = 1'h1;
    end
    b = s0 & s1;
  endtask
  // Waits for a dark pause, then counts pulses up to the next pause
  task burst(output int k);
    int lo;
    lo = 0;
    k = 0;
    while (lo < 12) begin
      @(posedge mclk);
      lo = (ledRed === 1'h1) ? 0 : lo + 1;
    end
    while (k == 0 || lo < 12) begin
      @(posedge mclk);
      if (ledRed === 1'h1 && lo > 0) k++;
      lo = (ledRed === 1'h1) ? 0 : lo + 1;
    end
  endtask
  task t_regs;
    apb(1'h0, `ILK_ADDR_CTRL, 32'h0);
    chkWord(rd, 32'h1);
    apb(1'h0, `ILK_ADDR_IRQ_EN, 32'h0);
    chkWord(rd, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chkWord(rd, 32'h0);
    chkBit(rdErr, 1'h1);
    apb(1'h1, `ILK_ADDR_IRQ_EN, 32'hF);
    apb(1'h0, `ILK_ADDR_IRQ_EN, 32'h0);
    chkWord(rd, 32'hF);
    apb(1'h1, `ILK_ADDR_CTRL, 32'h0);
    wc(2);
    chkBit(ledGreen, 1'h0);
    apb(1'h1, `ILK_ADDR_CTRL, 32'h1);
    wc(2);
    chkBit(ledGreen, 1'h1);
    $display("regs done");
  endtask
  task t_states;
    logic b;
    lag <= 4'h5;
    setp(1'h1, 1'h1, 1'h0, 1'h0);
    chkBit(first_safety_output, 1'h0);
    chkBit(diagOut, 1'h1);
    blink(b);
    chkBit(b, 1'h1);
    lockReq <= 1'h1;
    setp(1'h1, 1'h1, 1'h1, 1'h1);
    chkBit(first_safety_output, 1'h1);
    chkBit(diagOut, 1'h1);
    blink(b);
    chkBit(b, 1'h0);
    chkBit(ledYellow, 1'h1);
    setp(1'h1, 1'h1, 1'h1, 1'h0);
    chkBit(first_safety_output, 1'h0);
    chkBit(diagOut, 1'h0);
    blink(b);
    chkBit(b, 1'h1);
    pinActMarginal <= 1'h1;
    setp(1'h1, 1'h1, 1'h1, 1'h1);
    blink(b);
    chkBit(b, 1'h1);
    chkBit(first_safety_output, 1'h1);
    pinActMarginal <= 1'h0;
    lag <= 4'h1;
    $display("states done");
  endtask
  task t_warn(input int i, input logic [3:0] c);
    int k;
    err[i] <= 1'h1;
    wc(14);
    chkBit(first_safety_output, 1'h1);
    chkBit(diagOut, 1'h0);
    apb(1'h0, `ILK_ADDR_STATUS, 32'h0);
    chkWord({28'h0, rd[11:8]}, {28'h0, c});
    burst(k);
    chkWord(k, {28'h0, c});
    err[i] <= 1'h0;
    wc(14);
    chkBit(diagOut, 1'h1);
    $display("warn %0d done", c);
  endtask
  task t_escal;
    err[0] <= 1'h1;
    wc(640);
    chkBit(first_safety_output, 1'h0);
    chkBit(irq, 1'h1);
    apb(1'h1, `ILK_ADDR_IRQ_CLR, 32'hF);
    wc(2);
    chkBit(irq, 1'h0);
    apb(1'h1, `ILK_ADDR_IRQ_EN, 32'h0);
    // Guard cycle while the cause persists must not clear the failure
    setp(1'h0, 1'h1, 1'h0, 1'h1);
    setp(1'h1, 1'h1, 1'h1, 1'h1);
    chkBit(first_safety_output, 1'h0);
    err[0] <= 1'h0;
    wc(14);
    chkBit(first_safety_output, 1'h0);
    setp(1'h0, 1'h1, 1'h0, 1'h1);
    setp(1'h1, 1'h1, 1'h1, 1'h1);
    chkBit(first_safety_output, 1'h1);
    chkBit(irq, 1'h0);
    apb(1'h0, `ILK_ADDR_IRQ_STAT, 32'h0);
    chkBit(rd[`ILK_IRQ_CLEARED], 1'h1);
    $display("escalation done");
  endtask
  task t_imm(input int i, input logic [3:0] c);
    int k;
    err[i] <= 1'h1;
    wc(14);
    chkBit(first_safety_output, 1'h0);
    apb(1'h0, `ILK_ADDR_STATUS, 32'h0);
    chkWord({28'h0, rd[15:12]}, {28'h0, c});
    if (c == 4'hF) chkBit(ledRed, 1'h1);
    else begin
      burst(k);
      chkWord(k, {28'h0, c});
    end
    err[i] <= 1'h0;
    wc(14);
    chkBit(first_safety_output, 1'h0);
    setp(1'h0, 1'h1, 1'h0, 1'h1);
    setp(1'h1, 1'h1, 1'h1, 1'h1);
    chkBit(first_safety_output, 1'h1);
    $display("fault %0d done", c);
  endtask
  task t_cross;
    // Faults on both outputs share the cross-wire code
    err[1:0] <= 2'h3;
    wc(14);
    apb(1'h0, `ILK_ADDR_STATUS, 32'h0);
    chkWord({28'h0, rd[11:8]}, 32'h3);
    err[1:0] <= 2'h0;
    wc(14);
    err[2] <= 1'h1;
    wc(14);
    apb(1'h0, `ILK_ADDR_STATUS, 32'h0);
    chkWord({28'h0, rd[11:8]}, 32'h3);
    wc(640);
    chkBit(first_safety_output, 1'h0);
    err[2] <= 1'h0;
    setp(1'h0, 1'h1, 1'h0, 1'h1);
    setp(1'h1, 1'h1, 1'h1, 1'h1);
    chkBit(first_safety_output, 1'h0);
    sys_rst <= 1'h1;
    wc(20);
    sys_rst <= 1'h0;
    wc(14);
    chkBit(first_safety_output, 1'h1);
    $display("cross done");
  endtask
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      mismatches++;
      summarize;
    end
  end
  initial begin
    sys_rst = 1'h1;
    {pinGuardClosed, pinActPresent, pinActMarginal, pinLockEngaged} = 4'h0;
    {pinForceOk, lockReq, psel, penable, pwrite} = 5'h0;
    {paddr, pwdata, err, lag, mismatches, checks_done, cyc} = 0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
    t_regs;
    t_states;
    t_warn(0, 4'h1);
    t_warn(1, 4'h2);
    t_escal;
    t_imm(3, 4'h5);
    t_imm(4, 4'h6);
    t_imm(5, 4'hA);
    t_imm(6, 4'hF);
    t_cross;
    chkBit(pairBad, 1'h0);
    summarize;
  end
endmodule // ilk_diag_top_bench
`default_nettype wire
